// >>> core/scrp_pkg.sv
// package: constants, codes and types of the sensor command response port
package scrp_pkg;

   // ------------------------------------------------------------
   // operating mode reported by the internal microcontroller
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'h0,
      MODE_COMMAND = 2'h1,
      MODE_DIAG    = 2'h2
   } scrp_mode_t;

   // ------------------------------------------------------------
   // kind of output word refresh posted by the microcontroller
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      UPD_NORMAL   = 3'h0,
      UPD_DIAG     = 3'h1,
      UPD_DATA     = 3'h2,
      UPD_PAIR     = 3'h3,
      UPD_SUCCESS  = 3'h4,
      UPD_FAIL     = 3'h5,
      UPD_WRONG    = 3'h6,
      UPD_PROC_ERR = 3'h7
   } scrp_upd_t;

   // ------------------------------------------------------------
   // serial port state machine
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_AACK  = 7'h04,
      ST_WBYTE = 7'h08,
      ST_WACK  = 7'h10,
      ST_RBYTE = 7'h20,
      ST_RACK  = 7'h40
   } scrp_state_t;

   // ------------------------------------------------------------
   // response codes and fixed bytes
   // ------------------------------------------------------------
   localparam logic [7:0]  CS_BASE        = 8'hff;
   localparam logic [7:0]  LOW_NONE       = 8'h00;
   localparam logic [7:0]  SUCCESS_HI     = 8'hc3;
   localparam logic [7:0]  FAIL_HI        = 8'hcf;
   localparam logic [7:0]  DIAG_HI        = 8'hc0;
   localparam logic [15:0] WRONG_CMD_CODE = 16'hcf00;
   localparam logic [15:0] PROC_ERR_CODE  = 16'hc000;

   // ------------------------------------------------------------
   // command codes; the port itself recognises only CMD_ENTER_CM with ENTER_CM_KEY
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_ENTER_CM   = 8'h72;
   localparam logic [7:0]  ENTER_CM_KEY   = 8'hd1;
   localparam logic [7:0]  CMD_RAW_COUNT  = 8'h62;
   localparam logic [7:0]  CMD_OSC_TRIM   = 8'h65;
   localparam logic [7:0]  CMD_PUMP_EN    = 8'h6c;

   // ------------------------------------------------------------
   // positions, counts and reset values
   // ------------------------------------------------------------
   localparam int          ONE_WIRE_LIMIT_POS = 5;
   localparam logic [6:0]  PRIMARY_ADDR       = 7'h78;
   localparam logic [15:0] WORD_RESET         = 16'h0000;
   localparam logic [3:0]  BITS_PER_BYTE      = 4'h8;
   localparam int          SYNC_STAGES        = 2;

endpackage : scrp_pkg

// >>> core/scrp_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
module scrp_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   if (WIDTH < 1) begin : g_bad_width
      $error("scrp_sync: WIDTH must be at least 1");
   end

   // ------------------------------------------------------------
   // per-bit two-stage chain
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic stab_q;
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               meta_q <= 1'b1;
               stab_q <= 1'b1;
            end else begin
               meta_q <= async_in[i];
               stab_q <= meta_q;
            end
         end
         assign sync_out[i] = stab_q;
      end
   endgenerate

endmodule : scrp_sync

// >>> core/scrp_port.sv
// sensor command response port: serial slave, command hand-off, output words
module scrp_port #(
   parameter logic [6:0] DEV_ADDR = scrp_pkg::PRIMARY_ADDR
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   input  wire scrp_pkg::scrp_mode_t mode_in,
   input  wire logic [15:0]          ref_adj_word,
   output logic                      one_wire_en,
   output logic                      cmd_irq,
   output logic [7:0]                cmd_code,
   output logic [15:0]               cmd_data,
   output logic [1:0]                cmd_len,
   output logic                      cmd_busy,
   input  wire logic                 cmd_done,
   input  wire logic                 upd_valid,
   input  wire scrp_pkg::scrp_upd_t  upd_kind,
   input  wire logic [15:0]          upd_a,
   input  wire logic [15:0]          upd_b,
   output logic [15:0]               word_one,
   output logic [15:0]               word_two
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [1:0]            pins_s;
   logic                  scl_s;
   logic                  sda_s;
   logic                  scl_p_q;
   logic                  sda_p_q;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_cond;
   logic                  stop_cond;
   scrp_pkg::scrp_state_t state_q;
   logic [3:0]            bit_cnt_q;
   logic [7:0]            shift_q;
   logic                  ack_on_q;
   logic                  sda_oe_q;
   logic                  sda_out_q;
   logic [7:0]            tx_q;
   logic [15:0]           snap_q;
   logic [1:0]            rd_idx_q;
   logic [7:0]            next_byte;
   logic [15:0]           next_snap;
   logic                  wr_phase_q;
   logic [1:0]            wr_cnt_q;
   logic [7:0]            wr_cmd_q;
   logic [15:0]           wr_dat_q;
   logic                  wr_end;
   logic                  accept;
   logic                  cmd_irq_q;
   logic [7:0]            cmd_code_q;
   logic [15:0]           cmd_data_q;
   logic [1:0]            cmd_len_q;
   logic                  busy_q;
   logic [7:0]            echo_q;
   logic [15:0]           w1_q;
   logic [15:0]           w2_q;
   logic [15:0]           w1_d;
   logic [15:0]           w2_d;
   logic                  owi_en_q;

   function automatic logic [7:0] check_sum(input logic [15:0] w);
      check_sum = 8'(scrp_pkg::CS_BASE - 8'(w[15:8] + w[7:0]));
   endfunction : check_sum

   // ------------------------------------------------------------
   // pin synchronisation and bus condition detection
   // ------------------------------------------------------------
   scrp_sync #(
      .WIDTH (scrp_pkg::SYNC_STAGES)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in ({scl_in, sda_in}),
      .sync_out (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise   = scl_s & ~scl_p_q;
   assign scl_fall   = ~scl_s & scl_p_q;
   assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_cond  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ------------------------------------------------------------
   // read byte selection: word one high, low, word two high, low
   // ------------------------------------------------------------
   always_comb begin
      next_snap = snap_q;
      next_byte = snap_q[7:0];
      case (rd_idx_q)
         2'h0: begin
            next_snap = w1_q;
            next_byte = w1_q[15:8];
         end
         2'h1: begin
            next_byte = snap_q[7:0];
         end
         2'h2: begin
            next_snap = w2_q;
            next_byte = w2_q[15:8];
         end
         default: begin
            next_byte = snap_q[7:0];
         end
      endcase
   end

   // ------------------------------------------------------------
   // serial slave state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q    <= scrp_pkg::ST_IDLE;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         ack_on_q   <= 1'b0;
         sda_oe_q   <= 1'b0;
         sda_out_q  <= 1'b0;
         tx_q       <= 8'h00;
         snap_q     <= scrp_pkg::WORD_RESET;
         rd_idx_q   <= 2'h0;
         wr_phase_q <= 1'b0;
      end else if (start_cond) begin
         state_q    <= scrp_pkg::ST_ADDR;
         bit_cnt_q  <= 4'h0;
         ack_on_q   <= 1'b0;
         sda_oe_q   <= 1'b0;
         rd_idx_q   <= 2'h0;
         wr_phase_q <= 1'b0;
      end else if (stop_cond) begin
         state_q    <= scrp_pkg::ST_IDLE;
         sda_oe_q   <= 1'b0;
         wr_phase_q <= 1'b0;
      end else begin
         case (state_q)
            scrp_pkg::ST_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            scrp_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
                  if (bit_cnt_q == scrp_pkg::BITS_PER_BYTE - 4'h1) begin
                     if (shift_q[6:0] == DEV_ADDR) begin
                        state_q    <= scrp_pkg::ST_AACK;
                        wr_phase_q <= ~sda_s;
                     end else begin
                        state_q <= scrp_pkg::ST_IDLE;
                     end
                  end
               end
            end
            scrp_pkg::ST_AACK, scrp_pkg::ST_WACK: begin
               if (scl_fall) begin
                  if (!ack_on_q) begin
                     ack_on_q <= 1'b1;
                     sda_oe_q <= 1'b1;
                  end else begin
                     ack_on_q  <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     if (state_q == scrp_pkg::ST_AACK && !wr_phase_q) begin
                        state_q  <= scrp_pkg::ST_RBYTE;
                        snap_q   <= next_snap;
                        tx_q     <= next_byte;
                        sda_oe_q <= ~next_byte[7];
                        rd_idx_q <= 2'(rd_idx_q + 2'h1);
                     end else begin
                        state_q  <= scrp_pkg::ST_WBYTE;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
            end
            scrp_pkg::ST_WBYTE: begin
               if (scl_rise) begin
                  shift_q   <= {shift_q[6:0], sda_s};
                  bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
                  if (bit_cnt_q == scrp_pkg::BITS_PER_BYTE - 4'h1) begin
                     state_q <= scrp_pkg::ST_WACK;
                  end
               end
            end
            scrp_pkg::ST_RBYTE: begin
               if (scl_rise) begin
                  bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
               end else if (scl_fall) begin
                  if (bit_cnt_q == scrp_pkg::BITS_PER_BYTE) begin
                     state_q  <= scrp_pkg::ST_RACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     tx_q     <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= ~tx_q[6];
                  end
               end
            end
            scrp_pkg::ST_RACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state_q <= scrp_pkg::ST_IDLE;
                  end else begin
                     ack_on_q <= 1'b1;
                  end
               end else if (scl_fall && ack_on_q) begin
                  ack_on_q  <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  state_q   <= scrp_pkg::ST_RBYTE;
                  snap_q    <= next_snap;
                  tx_q      <= next_byte;
                  sda_oe_q  <= ~next_byte[7];
                  rd_idx_q  <= 2'(rd_idx_q + 2'h1);
               end
            end
            default: begin
               state_q  <= scrp_pkg::ST_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // write byte collection: command byte then up to two data bytes
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_cnt_q <= 2'h0;
         wr_cmd_q <= 8'h00;
         wr_dat_q <= 16'h0000;
      end else if (start_cond) begin
         wr_cnt_q <= 2'h0;
      end else if (state_q == scrp_pkg::ST_WBYTE && scl_rise
                   && bit_cnt_q == scrp_pkg::BITS_PER_BYTE - 4'h1) begin
         case (wr_cnt_q)
            2'h0: wr_cmd_q <= {shift_q[6:0], sda_s};
            2'h1: wr_dat_q[15:8] <= {shift_q[6:0], sda_s};
            2'h2: wr_dat_q[7:0] <= {shift_q[6:0], sda_s};
            default: wr_dat_q <= wr_dat_q;
         endcase
         if (wr_cnt_q != 2'h3) begin
            wr_cnt_q <= 2'(wr_cnt_q + 2'h1);
         end
      end
   end

   // ------------------------------------------------------------
   // command hand-off to the microcontroller
   // ------------------------------------------------------------
   assign wr_end = (stop_cond | start_cond) & wr_phase_q & (wr_cnt_q != 2'h0);
   assign accept = wr_end & ~busy_q
                   & ((mode_in == scrp_pkg::MODE_COMMAND)
                      | (wr_cmd_q == scrp_pkg::CMD_ENTER_CM
                         && wr_dat_q[15:8] == scrp_pkg::ENTER_CM_KEY));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_irq_q  <= 1'b0;
         cmd_code_q <= 8'h00;
         cmd_data_q <= 16'h0000;
         cmd_len_q  <= 2'h0;
         echo_q     <= scrp_pkg::LOW_NONE;
      end else begin
         cmd_irq_q <= accept;
         if (accept) begin
            cmd_code_q <= wr_cmd_q;
            cmd_data_q <= wr_dat_q;
            cmd_len_q  <= 2'(wr_cnt_q - 2'h1);
            echo_q     <= wr_cmd_q;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else if (accept) begin
         busy_q <= 1'b1;
      end else if (cmd_done) begin
         busy_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // output word composition by refresh kind
   // ------------------------------------------------------------
   always_comb begin
      w1_d = upd_a;
      w2_d = {check_sum(upd_a), echo_q};
      case (upd_kind)
         scrp_pkg::UPD_NORMAL: begin
            w1_d = upd_a;
            w2_d = {check_sum(upd_a), scrp_pkg::LOW_NONE};
         end
         scrp_pkg::UPD_DIAG: begin
            w1_d = {scrp_pkg::DIAG_HI, upd_a[7:0]};
            w2_d = {check_sum(w1_d), scrp_pkg::LOW_NONE};
         end
         scrp_pkg::UPD_DATA: begin
            w1_d = upd_a;
            w2_d = {check_sum(w1_d), echo_q};
         end
         scrp_pkg::UPD_PAIR: begin
            w1_d = upd_a;
            w2_d = upd_b;
         end
         scrp_pkg::UPD_SUCCESS: begin
            w1_d = {scrp_pkg::SUCCESS_HI, echo_q};
            w2_d = {check_sum(w1_d), echo_q};
         end
         scrp_pkg::UPD_FAIL: begin
            w1_d = {scrp_pkg::FAIL_HI, echo_q};
            w2_d = {check_sum(w1_d), echo_q};
         end
         scrp_pkg::UPD_WRONG: begin
            w1_d = scrp_pkg::WRONG_CMD_CODE;
            w2_d = {check_sum(w1_d), echo_q};
         end
         scrp_pkg::UPD_PROC_ERR: begin
            w1_d = scrp_pkg::PROC_ERR_CODE;
            w2_d = {check_sum(w1_d), echo_q};
         end
         default: begin
            w1_d = upd_a;
            w2_d = {check_sum(upd_a), echo_q};
         end
      endcase
      if (upd_kind == scrp_pkg::UPD_DIAG && mode_in == scrp_pkg::MODE_COMMAND) begin
         w2_d = {check_sum(w1_d), echo_q};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         w1_q <= scrp_pkg::WORD_RESET;
         w2_q <= scrp_pkg::WORD_RESET;
      end else if (upd_valid) begin
         w1_q <= w1_d;
         w2_q <= w2_d;
      end
   end

   // ------------------------------------------------------------
   // one-wire access limit
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         owi_en_q <= 1'b1;
      end else begin
         owi_en_q <= ~((mode_in == scrp_pkg::MODE_NORMAL)
                       & ref_adj_word[scrp_pkg::ONE_WIRE_LIMIT_POS]);
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sda_out     = sda_out_q;
   assign sda_oe      = sda_oe_q;
   assign one_wire_en = owi_en_q;
   assign cmd_irq     = cmd_irq_q;
   assign cmd_code    = cmd_code_q;
   assign cmd_data    = cmd_data_q;
   assign cmd_len     = cmd_len_q;
   assign cmd_busy    = busy_q;
   assign word_one    = w1_q;
   assign word_two    = w2_q;

endmodule : scrp_port

// >>> testbench/scrp_port_sva.sv
// checker: port relations of the command response port
module scrp_port_sva (
   input wire logic                 clk_sys,
   input wire logic                 rst,
   input wire logic                 sda_out,
   input wire scrp_pkg::scrp_mode_t mode_in,
   input wire logic [15:0]          ref_adj_word,
   input wire logic                 one_wire_en,
   input wire logic                 cmd_irq,
   input wire logic [7:0]           cmd_code,
   input wire logic                 cmd_busy,
   input wire logic                 cmd_done,
   input wire logic                 upd_valid,
   input wire scrp_pkg::scrp_upd_t  upd_kind,
   input wire logic [15:0]          upd_a,
   input wire logic [15:0]          upd_b,
   input wire logic [15:0]          word_one,
   input wire logic [15:0]          word_two
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ---
   // command hand-off, one-wire limit and open-drain data pin
   // ---
   a_irq_when_idle: assert property (cmd_irq |-> cmd_busy && !$past(cmd_busy) ##1 !cmd_irq)
      else $error("command taken while busy");
   a_busy_holds: assert property (cmd_busy && !cmd_done && !$past(cmd_done) |=> cmd_busy)
      else $error("busy dropped early");
   a_busy_ends: assert property (cmd_done |-> ##[1:2] !cmd_busy)
      else $error("busy not cleared");
   a_owi_limit: assert property (1'b1 |=> one_wire_en == !($past(mode_in) == scrp_pkg::MODE_NORMAL
      && $past(ref_adj_word[scrp_pkg::ONE_WIRE_LIMIT_POS])))
      else $error("one wire enable wrong");
   a_open_drain: assert property (!sda_out)
      else $error("data pin driven high");
   // ---
   // output words
   // ---
   a_cs_byte: assert property (upd_valid && upd_kind != scrp_pkg::UPD_PAIR |=>
      word_two[15:8] == scrp_pkg::CS_BASE - word_one[15:8] - word_one[7:0])
      else $error("check sum wrong");
   a_success_code: assert property (upd_valid && upd_kind == scrp_pkg::UPD_SUCCESS |=>
      word_one == {8'hc3, cmd_code} && word_two[7:0] == cmd_code)
      else $error("success code wrong");
   a_fail_code: assert property (upd_valid && upd_kind == scrp_pkg::UPD_FAIL |=>
      word_one == {8'hcf, cmd_code})
      else $error("fail code wrong");
   a_wrong_code: assert property (upd_valid && upd_kind == scrp_pkg::UPD_WRONG |=>
      word_one == 16'hcf00)
      else $error("wrong command code wrong");
   a_proc_code: assert property (upd_valid && upd_kind == scrp_pkg::UPD_PROC_ERR |=>
      word_one == 16'hc000)
      else $error("processing error code wrong");
   a_normal_word: assert property (upd_valid && upd_kind == scrp_pkg::UPD_NORMAL |=>
      word_one == $past(upd_a) && word_two[7:0] == 8'h00)
      else $error("normal words wrong");
   a_diag_word: assert property (upd_valid && upd_kind == scrp_pkg::UPD_DIAG |=>
      word_one == {8'hc0, $past(upd_a[7:0])})
      else $error("diagnostic word wrong");
   a_pair_word: assert property (upd_valid && upd_kind == scrp_pkg::UPD_PAIR |=>
      word_one == $past(upd_a) && word_two == $past(upd_b))
      else $error("raw pair wrong");
   a_words_hold: assert property (!upd_valid |=> $stable(word_one) && $stable(word_two))
      else $error("words changed without refresh");
endmodule : scrp_port_sva

// >>> testbench/scrp_master.sv
// bus master model for the serial port
module scrp_master (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      sda_pull = !b;
      #200 scl = 1'b1;
      #200 r = sda;
      #200 scl = 1'b0;
      #200;
   endtask : bit_io
   task automatic start;
      sda_pull = 1'b0;
      #400 sda_pull = 1'b1;
      #400 scl = 1'b0;
      #200;
   endtask : start
   task automatic stop;
      sda_pull = 1'b1;
      #200 scl = 1'b1;
      #400 sda_pull = 1'b0;
      #400;
   endtask : stop
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(last, ack);
   endtask : xfer
endmodule : scrp_master

// >>> testbench/sensor_command_response_port_tb.sv
// testbench: command hand-off and output words of the response port
module sensor_command_response_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk_sys = 1'b0;
   logic                rst, scl, sda_pull, sda, sda_out, sda_oe, one_wire_en;
   logic                cmd_irq, cmd_busy, cmd_done, upd_valid;
   logic [7:0]          cmd_code;
   logic [15:0]         cmd_data, ref_adj_word, upd_a, upd_b, word_one, word_two;
   logic [1:0]          cmd_len;
   logic [15:0]         irq_n = 16'h0000;
   logic [7:0]          nr;
   logic                na;
   scrp_pkg::scrp_mode_t mode_in;
   scrp_pkg::scrp_upd_t  upd_kind;
   scrp_pkg::scrp_upd_t  kinds [4] = '{scrp_pkg::UPD_SUCCESS, scrp_pkg::UPD_FAIL,
                                       scrp_pkg::UPD_WRONG, scrp_pkg::UPD_PROC_ERR};
   logic [15:0]         codes [4] = '{16'hc36c, 16'hcf6c, 16'hcf00, 16'hc000};
   int                  bad_count = 0, checks = 0, cycles = 0;
   assign sda = !(sda_pull || (sda_oe && !sda_out));
   always #50 clk_sys = !clk_sys;
   scrp_master u_mst (.scl(scl), .sda_pull(sda_pull), .sda(sda));
   scrp_port dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .mode_in(mode_in), .ref_adj_word(ref_adj_word),
      .one_wire_en(one_wire_en), .cmd_irq(cmd_irq), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .cmd_len(cmd_len), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .upd_valid(upd_valid),
      .upd_kind(upd_kind), .upd_a(upd_a), .upd_b(upd_b), .word_one(word_one),
      .word_two(word_two));
   always @(posedge clk_sys) begin
      cycles++;
      if (cmd_irq === 1'b1) irq_n <= irq_n + 16'h0001;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   // ---
   // tasks
   // ---
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [15:0] w2(input logic [15:0] w, input logic [7:0] lo);
      return {8'hff - w[15:8] - w[7:0], lo};
   endfunction : w2
   task automatic send(input logic [7:0] c, input logic [15:0] d, input int n);
      logic [7:0] r;
      logic       a;
      u_mst.start();
      u_mst.xfer({scrp_pkg::PRIMARY_ADDR, 1'b0}, 1'b1, r, a);
      check(a, 1'b0);
      u_mst.xfer(c, 1'b1, r, a);
      for (int i = 0; i < n; i++) u_mst.xfer(d[15-8*i -: 8], 1'b1, r, a);
      u_mst.stop();
      repeat (6) @(posedge clk_sys);
      #10;
   endtask : send
   task automatic read_words(input logic [15:0] e1, input logic [15:0] e2);
      logic [47:0] v;
      logic        a;
      u_mst.start();
      u_mst.xfer({scrp_pkg::PRIMARY_ADDR, 1'b1}, 1'b1, v[7:0], a);
      for (int i = 5; i >= 0; i--) u_mst.xfer(8'hff, i == 0, v[8*i +: 8], a);
      u_mst.stop();
      check(v[47:32], e1);
      check(v[31:16], e2);
      check(v[15:0], e1);
   endtask : read_words
   task automatic post(input scrp_pkg::scrp_upd_t k, input logic [15:0] a, input logic [15:0] b);
      upd_kind = k;
      upd_a = a;
      upd_b = b;
      upd_valid = 1'b1;
      @(posedge clk_sys);
      #10 upd_valid = 1'b0;
      @(posedge clk_sys);
      #10;
   endtask : post
   task automatic finish_cmd;
      cmd_done = 1'b1;
      @(posedge clk_sys);
      #10 cmd_done = 1'b0;
      repeat (2) @(posedge clk_sys);
      #10 check(cmd_busy, 1'b0);
   endtask : finish_cmd
   task automatic end_of_test;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // ---
   // sequence
   // ---
   initial begin
      rst = 1'b1;
      mode_in = scrp_pkg::MODE_NORMAL;
      ref_adj_word = 16'h0020;
      cmd_done = 1'b0;
      upd_valid = 1'b0;
      upd_kind = scrp_pkg::UPD_NORMAL;
      upd_a = 16'h0000;
      upd_b = 16'h0000;
      repeat (6) @(posedge clk_sys);
      #10 rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #10 check(word_one, 16'h0000);
      check(one_wire_en, 1'b0);
      mode_in = scrp_pkg::MODE_COMMAND;
      repeat (2) @(posedge clk_sys);
      #10 check(one_wire_en, 1'b1);
      mode_in = scrp_pkg::MODE_NORMAL;
      send(8'h10, 16'h0000, 0);
      check(irq_n, 16'h0000);
      u_mst.start();
      u_mst.xfer({7'h11, 1'b0}, 1'b1, nr, na);
      u_mst.stop();
      check(na, 1'b1);
      send(scrp_pkg::CMD_ENTER_CM, 16'hd100, 1);
      check(irq_n, 16'h0001);
      check({cmd_code, cmd_data[15:8]}, 16'h72d1);
      mode_in = scrp_pkg::MODE_COMMAND;
      send(8'h30, 16'h0000, 0);
      check(irq_n, 16'h0001);
      finish_cmd();
      post(scrp_pkg::UPD_SUCCESS, 16'h0000, 16'h0000);
      read_words(16'hc372, w2(16'hc372, 8'h72));
      send(scrp_pkg::CMD_PUMP_EN, 16'hf742, 2);
      check(cmd_data, 16'hf742);
      check({14'h0000, cmd_len}, 16'h0002);
      finish_cmd();
      for (int i = 0; i < 4; i++) begin
         post(kinds[i], 16'h0000, 16'h0000);
         check(word_one, codes[i]);
         check(word_two, w2(codes[i], 8'h6c));
      end
      send(scrp_pkg::CMD_OSC_TRIM, 16'h1234, 2);
      finish_cmd();
      post(scrp_pkg::UPD_DATA, 16'h1234, 16'h0000);
      read_words(16'h1234, w2(16'h1234, 8'h65));
      post(scrp_pkg::UPD_PAIR, 16'h0abc, 16'h0def);
      read_words(16'h0abc, 16'h0def);
      post(scrp_pkg::UPD_DIAG, 16'h0007, 16'h0000);
      check(word_one, 16'hc007);
      check(word_two, w2(16'hc007, 8'h65));
      mode_in = scrp_pkg::MODE_NORMAL;
      post(scrp_pkg::UPD_NORMAL, 16'h8123, 16'h0000);
      read_words(16'h8123, w2(16'h8123, 8'h00));
      mode_in = scrp_pkg::MODE_DIAG;
      post(scrp_pkg::UPD_DIAG, 16'h0005, 16'h0000);
      read_words(16'hc005, w2(16'hc005, 8'h00));
      end_of_test();
   end
endmodule : sensor_command_response_port_tb
bind scrp_port scrp_port_sva u_sva (.clk_sys(clk_sys), .rst(rst), .sda_out(sda_out),
   .mode_in(mode_in), .ref_adj_word(ref_adj_word), .one_wire_en(one_wire_en),
   .cmd_irq(cmd_irq), .cmd_code(cmd_code), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
   .upd_valid(upd_valid), .upd_kind(upd_kind), .upd_a(upd_a), .upd_b(upd_b),
   .word_one(word_one), .word_two(word_two));
